// ### fric_ctrl.v
// fric_ctrl.v: flash rewrite sequencer with interrupt, suspend and abort control
// assumes all inputs synchronous to i_clk_sys; the flash array itself is outside
`timescale 1ns/1ps
`include "fric_defines.vh"

// How it works
// - rom mode, suspend enabled: maskable irq in erase suspends after latency, then acks
// - software clearing the suspend request resumes the suspended erase
// - while suspended, reads and programs allowed except the suspended block
// - rom mode, suspend off or programming: maskable irq held until operation ends
// - urgent irq during erase or program aborts, resets flash, acks after restart
// - ready flag low during blank check, high when it finishes
// - erase command while suspended sets both error flags
module fric_ctrl #(
  parameter [`FRIC_CNT_W-1:0] ERASE_CYC = `FRIC_ERASE_CYC_DEF,
  parameter [`FRIC_CNT_W-1:0] PROG_CYC  = `FRIC_PROG_CYC_DEF,
  parameter [`FRIC_CNT_W-1:0] BLANK_CYC = `FRIC_BLANK_CYC_DEF
) (
  // clock, reset, enable
  input  wire                   i_clk_sys,
  input  wire                   i_rst,
  input  wire                   i_ce,
  // protected control bit writes
  input  wire                   i_ctl_wr,
  input  wire [`FRIC_SEL_W-1:0] i_ctl_sel,
  input  wire                   i_ctl_wdata,
  // suspend request bit
  input  wire                   i_susp_req_set,
  input  wire                   i_susp_req_clr,
  // commands
  input  wire                   i_cmd_valid,
  input  wire [`FRIC_CMD_W-1:0] i_cmd_code,
  input  wire [`FRIC_BLK_W-1:0] i_cmd_block,
  input  wire                   i_op_fail,
  input  wire                   i_blank_ok,
  input  wire                   i_err_clr,
  // reads
  input  wire                   i_rd_valid,
  input  wire [`FRIC_BLK_W-1:0] i_rd_block,
  // interrupts
  input  wire                   i_irq,
  input  wire                   i_urgent_irq,
  // status
  output reg  [`FRIC_NPROT-1:0] o_ctl_bits,
  output reg                    o_susp_req,
  output reg                    o_suspended,
  output reg                    o_ready,
  output reg                    o_erase_err,
  output reg                    o_program_err,
  output reg                    o_rd_allow,
  output reg                    o_irq_ack,
  output reg                    o_urgent_ack,
  output reg                    o_flash_reset
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_ERASE = 7'h02;
  localparam [6:0] ST_SWAIT = 7'h04;
  localparam [6:0] ST_SUSP  = 7'h08;
  localparam [6:0] ST_PROG  = 7'h10;
  localparam [6:0] ST_BLANK = 7'h20;
  localparam [6:0] ST_RST   = 7'h40;
  localparam [`FRIC_CNT_W-1:0] SUSP_LAT_CYC = `FRIC_SUSP_LAT_CYC;
  localparam [`FRIC_CNT_W-1:0] RESTART_CYC  = `FRIC_RESTART_CYC;
  localparam [`FRIC_CNT_W-1:0] CNT_ONE      = 20'h00001;

  reg [6:0]             state_r;
  reg [`FRIC_CNT_W-1:0] cnt_r;
  reg [`FRIC_CNT_W-1:0] erase_left_r;
  reg [`FRIC_BLK_W-1:0] blk_r;
  reg                   in_susp_r;
  reg                   last_vld_r;
  reg [`FRIC_SEL_W-1:0] last_sel_r;
  reg                   last_val_r;

  wire mode_en  = o_ctl_bits[`FRIC_B_MODE_EN];
  wire rom_mode = o_ctl_bits[`FRIC_B_MODE_OPT];
  wire susp_en  = o_ctl_bits[`FRIC_B_SUSP_EN];
  wire cnt_done = (cnt_r == CNT_ONE);
  wire busy_op  = (state_r == ST_ERASE) | (state_r == ST_SWAIT) |
                  (state_r == ST_PROG) | (state_r == ST_BLANK);
  wire cmd_go   = i_cmd_valid & mode_en;
  wire susp_hw  = (state_r == ST_ERASE) & rom_mode & susp_en & i_irq;
  wire irq_ok   = (state_r == ST_IDLE) | (state_r == ST_SUSP) |
                  (busy_op & ~rom_mode) | ~mode_en;
  wire urg_ok   = ~busy_op & (state_r != ST_RST);
  wire cmd_bad  = cmd_go & (i_cmd_code != {`FRIC_CMD_W{1'b0}}) &
                  ((i_cmd_code != `FRIC_CMD_PROG) | (i_cmd_block == blk_r));
  wire [`FRIC_NPROT-1:0] prot_take;

  // ----------------------------------------------------------------
  // protected control bits
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `FRIC_NPROT; gi = gi + 1) begin : g_prot
      wire hit  = i_ctl_wr & (i_ctl_sel == gi);
      wire pair = last_vld_r & (last_sel_r == gi) & (last_val_r != i_ctl_wdata);
      wire acc  = (gi < `FRIC_NSETP) ? (~i_ctl_wdata | pair) : (i_ctl_wdata | pair);
      assign prot_take[gi] = hit & acc;
    end
  endgenerate

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ctl_bits <= `FRIC_PROT_RST;
    end else if (i_ce) begin
      o_ctl_bits <= (o_ctl_bits & ~prot_take) | ({`FRIC_NPROT{i_ctl_wdata}} & prot_take);
    end
  end

  // pairing memory broken by any acknowledged interrupt between the two writes
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      last_vld_r <= 1'b0;
      last_sel_r <= {`FRIC_SEL_W{1'b0}};
      last_val_r <= 1'b0;
    end else if (i_ce) begin
      if (i_ctl_wr) begin
        last_vld_r <= 1'b1;
        last_sel_r <= i_ctl_sel;
        last_val_r <= i_ctl_wdata;
      end else if (o_irq_ack | o_urgent_ack) begin
        last_vld_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_r       <= ST_IDLE;
      cnt_r         <= {`FRIC_CNT_W{1'b0}};
      erase_left_r  <= {`FRIC_CNT_W{1'b0}};
      blk_r         <= {`FRIC_BLK_W{1'b0}};
      in_susp_r     <= 1'b0;
      o_susp_req    <= 1'b0;
      o_suspended   <= 1'b0;
      o_ready       <= 1'b1;
      o_erase_err   <= 1'b0;
      o_program_err <= 1'b0;
      o_rd_allow    <= 1'b0;
      o_irq_ack     <= 1'b0;
      o_urgent_ack  <= 1'b0;
      o_flash_reset <= 1'b0;
    end else if (i_ce) begin
      o_irq_ack    <= i_irq & irq_ok;
      o_urgent_ack <= i_urgent_irq & urg_ok;
      o_rd_allow   <= i_rd_valid & ((state_r == ST_IDLE) |
                      ((state_r == ST_SUSP) & (i_rd_block != blk_r)));
      // error flags: a set in this cycle beats the clear
      if (i_err_clr) begin
        o_erase_err   <= 1'b0;
        o_program_err <= 1'b0;
      end
      // suspend request: hardware or software set beats software clear
      if (susp_hw | i_susp_req_set) begin
        o_susp_req <= 1'b1;
      end else if (i_susp_req_clr) begin
        o_susp_req <= 1'b0;
      end
      if (i_urgent_irq & busy_op) begin
        state_r       <= ST_RST;
        cnt_r         <= RESTART_CYC;
        in_susp_r     <= 1'b0;
        o_susp_req    <= 1'b0;
        o_suspended   <= 1'b0;
        o_ready       <= 1'b0;
        o_flash_reset <= 1'b1;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (cmd_go) begin
              blk_r   <= i_cmd_block;
              o_ready <= 1'b0;
              if (i_cmd_code == `FRIC_CMD_ERASE) begin
                state_r <= ST_ERASE;
                cnt_r   <= ERASE_CYC;
              end else if (i_cmd_code == `FRIC_CMD_PROG) begin
                state_r <= ST_PROG;
                cnt_r   <= PROG_CYC;
              end else if (i_cmd_code == `FRIC_CMD_BLANK) begin
                state_r <= ST_BLANK;
                cnt_r   <= BLANK_CYC;
              end else begin
                o_ready <= 1'b1;
              end
            end
          end
          ST_ERASE: begin
            if (cnt_done) begin
              state_r <= ST_IDLE;
              o_ready <= 1'b1;
              if (i_op_fail) begin
                o_erase_err <= 1'b1;
              end
            end else if (susp_hw | o_susp_req) begin
              state_r      <= ST_SWAIT;
              erase_left_r <= cnt_r - CNT_ONE;
              cnt_r        <= SUSP_LAT_CYC;
            end else begin
              cnt_r <= cnt_r - CNT_ONE;
            end
          end
          ST_SWAIT: begin
            if (cnt_done) begin
              state_r     <= ST_SUSP;
              o_suspended <= 1'b1;
              o_ready     <= 1'b1;
            end else begin
              cnt_r <= cnt_r - CNT_ONE;
            end
          end
          ST_SUSP: begin
            if (cmd_bad) begin
              o_erase_err   <= 1'b1;
              o_program_err <= 1'b1;
            end else if (cmd_go & (i_cmd_code == `FRIC_CMD_PROG)) begin
              state_r   <= ST_PROG;
              cnt_r     <= PROG_CYC;
              in_susp_r <= 1'b1;
              o_ready   <= 1'b0;
            end else if (~o_susp_req) begin
              state_r     <= ST_ERASE;
              cnt_r       <= erase_left_r;
              o_suspended <= 1'b0;
              o_ready     <= 1'b0;
            end
          end
          ST_PROG: begin
            if (cnt_done) begin
              state_r   <= in_susp_r ? ST_SUSP : ST_IDLE;
              in_susp_r <= 1'b0;
              o_ready   <= 1'b1;
              if (i_op_fail) begin
                o_program_err <= 1'b1;
              end
            end else begin
              cnt_r <= cnt_r - CNT_ONE;
            end
          end
          ST_BLANK: begin
            if (cnt_done) begin
              state_r <= ST_IDLE;
              o_ready <= 1'b1;
              if (~i_blank_ok) begin
                o_erase_err <= 1'b1;
              end
            end else begin
              cnt_r <= cnt_r - CNT_ONE;
            end
          end
          ST_RST: begin
            if (cnt_done) begin
              state_r       <= ST_IDLE;
              o_ready       <= 1'b1;
              o_flash_reset <= 1'b0;
            end else begin
              cnt_r <= cnt_r - CNT_ONE;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ### fric_defines.vh
// fric_defines.vh: constants of the flash rewrite interrupt controller
// assumes one 200 MHz system clock; no process or assignment lives here
`ifndef FRIC_DEFINES_VH
`define FRIC_DEFINES_VH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define FRIC_CLK_PERIOD_NS   5

// ----------------------------------------------------------------
// timing (times in ns, counts derived, least times round up)
// ----------------------------------------------------------------
`define FRIC_SUSP_LAT_NS     2000
`define FRIC_RESTART_NS      5000
`define FRIC_SUSP_LAT_CYC    ((`FRIC_SUSP_LAT_NS + `FRIC_CLK_PERIOD_NS - 1) / `FRIC_CLK_PERIOD_NS)
`define FRIC_RESTART_CYC     ((`FRIC_RESTART_NS + `FRIC_CLK_PERIOD_NS - 1) / `FRIC_CLK_PERIOD_NS)
`define FRIC_ERASE_CYC_DEF   200000
`define FRIC_PROG_CYC_DEF    8000
`define FRIC_BLANK_CYC_DEF   6000
`define FRIC_CNT_W           20

// ----------------------------------------------------------------
// commands
// ----------------------------------------------------------------
`define FRIC_CMD_W           2
`define FRIC_CMD_PROG        2'h1
`define FRIC_CMD_ERASE       2'h2
`define FRIC_CMD_BLANK       2'h3
`define FRIC_BLK_W           4

// ----------------------------------------------------------------
// protected control bits: index in the control vector
// ----------------------------------------------------------------
`define FRIC_SEL_W           4
`define FRIC_NPROT           10
`define FRIC_NSETP           6
`define FRIC_B_MODE_EN       0
`define FRIC_B_MODE_OPT      1
`define FRIC_B_SECOND_PROT   2
`define FRIC_B_REWRITE_EN    3
`define FRIC_B_SUSP_EN       4
`define FRIC_B_LOW_CUR       5
`define FRIC_B_UPPER_A       6
`define FRIC_B_UPPER_D       9
`define FRIC_PROT_RST        10'h000

`endif

// ### fric_cpu_model.sv
// fric_cpu_model.sv: cpu-side writer of the protected control bits
// assumes its task is entered at a falling edge of i_clk_sys
`timescale 1ns/1ps
`include "fric_defines.vh"
module fric_cpu_model (
  input  wire                   i_clk_sys,
  output reg                    o_wr,
  output reg  [`FRIC_SEL_W-1:0] o_sel,
  output reg                    o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_sel = 4'h0;
    o_wdata = 1'b0;
  end
  // paired: opposite value then target, strobe held, no gap
  // no traps, stop or wait; clock ratio fixed before low-current read
  task put(input [3:0] sel, input v, input pair);
    o_wr = 1'b1;
    o_sel = sel;
    o_wdata = pair ? ~v : v;
    if (pair) begin
      @(negedge i_clk_sys);
      o_wdata = v;
    end
    @(negedge i_clk_sys);
    o_wr = 1'b0;
  endtask
endmodule

// ### fric_ctrl_asserts.sv
// fric_ctrl_asserts.sv: port checks of the flash rewrite controller
// assumes binding into fric_ctrl; checks idle while i_ce is low
`timescale 1ns/1ps
`include "fric_defines.vh"
module fric_ctrl_asserts #(
  parameter [`FRIC_CNT_W-1:0] ERASE_CYC = `FRIC_ERASE_CYC_DEF,
  parameter [`FRIC_CNT_W-1:0] PROG_CYC  = `FRIC_PROG_CYC_DEF,
  parameter [`FRIC_CNT_W-1:0] BLANK_CYC = `FRIC_BLANK_CYC_DEF
) (
  input wire                   i_clk_sys, i_rst, i_ce, i_ctl_wr, i_ctl_wdata,
  input wire [`FRIC_SEL_W-1:0] i_ctl_sel,
  input wire                   i_susp_req_set, i_susp_req_clr, i_cmd_valid, i_op_fail,
  input wire [`FRIC_CMD_W-1:0] i_cmd_code,
  input wire [`FRIC_BLK_W-1:0] i_cmd_block, i_rd_block,
  input wire                   i_blank_ok, i_err_clr, i_rd_valid, i_irq, i_urgent_irq,
  input wire [`FRIC_NPROT-1:0] o_ctl_bits,
  input wire                   o_susp_req, o_suspended, o_ready, o_erase_err, o_program_err,
  input wire                   o_rd_allow, o_irq_ack, o_urgent_ack, o_flash_reset
);
  reg  [10:0] rst_cnt_r;
  reg  [3:0]  last_sel_r;
  reg         last_d_r;
  reg         last_ok_r;
  wire        paired  = last_ok_r && last_sel_r == i_ctl_sel && last_d_r != i_ctl_wdata;
  wire        guarded = (i_ctl_sel < 4'h6) ? i_ctl_wdata : (i_ctl_sel < 4'ha && !i_ctl_wdata);
  // ----------------------------------------------------------------
  // restart length and last protected write
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rst_cnt_r <= 11'h000;
      last_sel_r <= 4'h0;
      last_d_r <= 1'b0;
      last_ok_r <= 1'b0;
    end else if (i_ce) begin
      rst_cnt_r <= o_flash_reset ? rst_cnt_r + 11'h001 : 11'h000;
      if (i_ctl_wr) begin
        last_sel_r <= i_ctl_sel;
        last_d_r <= i_ctl_wdata;
        last_ok_r <= 1'b1;
      end else if (o_irq_ack || o_urgent_ack) begin
        last_ok_r <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst || !i_ce);
  a_prot_refused: assert property (i_ctl_wr && guarded && !paired |=> $stable(o_ctl_bits))
    else $error("unpaired protected write changed a bit");
  a_prot_taken: assert property (i_ctl_wr && i_ctl_sel < 4'ha && (!guarded || paired)
    |=> o_ctl_bits[$past(i_ctl_sel)] == $past(i_ctl_wdata)) else $error("bit write lost");
  a_cmd_busy: assert property (i_cmd_valid && i_cmd_code != 2'h0 && o_ready && !o_suspended
    && o_ctl_bits[0] |=> !o_ready) else $error("command did not go busy");
  a_susp_err: assert property (i_cmd_valid && o_suspended && o_ready && o_ctl_bits[0]
    && i_cmd_code == 2'h2 |=> o_erase_err && o_program_err) else $error("no sequence error");
  a_urgent_abort: assert property (i_urgent_irq && !o_ready && !o_flash_reset
    |=> o_flash_reset && !o_ready && !o_suspended) else $error("urgent irq did not abort");
  a_restart_len: assert property ($fell(o_flash_reset) |-> rst_cnt_r == `FRIC_RESTART_CYC)
    else $error("flash restart length wrong");
  a_susp_lat: assert property ($rose(o_suspended) |-> $past(o_susp_req, `FRIC_SUSP_LAT_CYC))
    else $error("suspend came before its latency");
  a_irq_held: assert property (o_ctl_bits[1] && !o_ready |=> !o_irq_ack)
    else $error("maskable irq acked while busy");
  a_susp_ack: assert property (o_suspended && o_ready && i_irq && !i_urgent_irq |=> o_irq_ack)
    else $error("irq not served while suspended");
  a_resume: assert property (o_suspended && i_susp_req_clr && !i_susp_req_set && !i_irq
    && !i_urgent_irq |=> !o_susp_req ##1 (!o_suspended && !o_ready)) else $error("no resume");
  a_rd_idle: assert property (i_rd_valid && o_ready && !o_suspended |=> o_rd_allow)
    else $error("read refused while idle");
endmodule
bind fric_ctrl fric_ctrl_asserts #(
  .ERASE_CYC(ERASE_CYC),
  .PROG_CYC (PROG_CYC),
  .BLANK_CYC(BLANK_CYC)
) i_fric_ctrl_asserts (.*);

// ### fric_ctrl_bench.sv
// fric_ctrl_bench.sv: self-checking bench of the flash rewrite controller
// assumes fric_cpu_model as the writer of the protected bits
`timescale 1ns/1ps
`include "fric_defines.vh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t got %h exp %h", $time, got, exp); end end
module fric_ctrl_bench;
  localparam int EC = 1000, PC = 10, BC = 8;
  logic i_clk_sys, i_rst, i_ce, i_ctl_wr, i_ctl_wdata, i_susp_req_set, i_susp_req_clr;
  logic i_cmd_valid, i_op_fail, i_blank_ok, i_err_clr, i_rd_valid, i_irq, i_urgent_irq;
  logic [3:0] i_ctl_sel, i_cmd_block, i_rd_block;
  logic [1:0] i_cmd_code;
  logic [9:0] o_ctl_bits, e_bits;
  logic o_susp_req, o_suspended, o_ready, o_erase_err, o_program_err;
  logic o_rd_allow, o_irq_ack, o_urgent_ack, o_flash_reset, l_d, e_pe, e_ee;
  logic [31:0] seed = 32'he41f;
  int err_count, checks, n, i, l_sel;
  fric_ctrl #(.ERASE_CYC(20'h003e8), .PROG_CYC(20'h0000a), .BLANK_CYC(20'h00008)) i_fric_ctrl (.*);
  fric_cpu_model i_fric_cpu_model (
    .i_clk_sys(i_clk_sys), .o_wr(i_ctl_wr), .o_sel(i_ctl_sel), .o_wdata(i_ctl_wdata));
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cyc(input int k); repeat (k) @(negedge i_clk_sys); endtask
  task done(input string s); $display("test %s done", s); endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // reference model and drivers
  // ----------------------------------------------------------------
  task ctl(input int s, input logic v, input logic p);
    i_fric_cpu_model.put(s[3:0], v, p);
    if (p) begin
      if (v == (s < 6)) e_bits[s] = v;
    end else if (v != (s < 6) || (l_sel == s && l_d != v)) e_bits[s] = v;
    l_sel = s;
    l_d = v;
    `CHK(o_ctl_bits, e_bits)
    cyc(1);
  endtask
  task issue(input logic [1:0] c, input logic [3:0] b);
    i_cmd_code = c; i_cmd_block = b; i_cmd_valid = 1'b1;
    cyc(1);
    i_cmd_valid = 1'b0;
  endtask
  task clr; i_err_clr = 1'b1; cyc(1); i_err_clr = 1'b0; e_pe = 1'b0; e_ee = 1'b0; endtask
  task wait_rdy(input logic irq_on);
    n = 1;
    while (o_ready !== 1'b1 && n < 5000) begin
      if (irq_on) `CHK(o_irq_ack, (n == 1) || !e_bits[1])
      cyc(1);
      n++;
    end
  endtask
  task op(input logic [1:0] c, input logic [3:0] b, input int len, input logic irq);
    seed = lfsr(seed);
    i_op_fail = seed[0]; i_blank_ok = seed[1]; i_irq = irq;
    issue(c, b);
    wait_rdy(irq);
    `CHK(n, len + 1)
    if (c == 2'h1) e_pe = e_pe | i_op_fail;
    else e_ee = e_ee | ((c == 2'h2) ? i_op_fail : ~i_blank_ok);
    `CHK({o_program_err, o_erase_err}, {e_pe, e_ee})
  endtask
  task rd(input logic [3:0] b, input logic exp);
    i_rd_valid = 1'b1; i_rd_block = b;
    cyc(1);
    `CHK(o_rd_allow, exp)
    i_rd_valid = 1'b0;
    cyc(1);
  endtask
  initial begin
    #200000;
    err_count++;
    wrap_up;
  end
  initial begin
    {i_rst, i_ce, i_susp_req_set, i_susp_req_clr, i_cmd_valid, i_op_fail} = 6'h30;
    {i_blank_ok, i_err_clr, i_rd_valid, i_irq, i_urgent_irq, e_pe, e_ee} = 7'h00;
    {i_cmd_code, i_cmd_block, i_rd_block, e_bits} = 20'h00000;
    err_count = 0; checks = 0; l_sel = -1; l_d = 1'b0;
    repeat (5) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_rst = 1'b0;
    `CHK({o_ready, o_ctl_bits}, 11'h400)
    ctl(9, 1'b1, 1'b0);
    for (i = 0; i < 6; i++) ctl(i, 1'b1, 1'b0);
    for (i = 0; i < 10; i++) ctl(i, i < 6, 1'b1);
    ctl(8, 1'b1, 1'b0); ctl(7, 1'b1, 1'b0); ctl(8, 1'b0, 1'b0);
    done("protected writes");
    ctl(4, 1'b0, 1'b0);
    for (i = 1; i < 4; i++) begin
      op(i[1:0], i[3:0], (i == 1) ? PC : (i == 2) ? EC : BC, 1'b1);
      clr;
      `CHK(o_irq_ack, 1'b1)
    end
    i_irq = 1'b0;
    done("held interrupts");
    ctl(4, 1'b1, 1'b1);
    issue(2'h2, 4'h5);
    cyc(50);
    i_irq = 1'b1;
    n = 0;
    while (o_suspended !== 1'b1 && n < 1000) begin cyc(1); n++; end
    `CHK(n, `FRIC_SUSP_LAT_CYC + 1)
    cyc(1);
    `CHK({o_ready, o_susp_req, o_irq_ack}, 3'h7)
    i_irq = 1'b0;
    rd(4'h5, 1'b0); rd(4'h6, 1'b1);
    op(2'h1, 4'h6, PC, 1'b0);
    `CHK(o_suspended, 1'b1)
    clr;
    for (i = 1; i < 4; i++) begin
      issue((i == 1) ? 2'h1 : 2'h2, (i == 3) ? 4'h6 : 4'h5);
      `CHK({o_erase_err, o_program_err, o_suspended}, 3'h7)
      clr;
    end
    i_susp_req_clr = 1'b1; cyc(1); i_susp_req_clr = 1'b0;
    cyc(1);
    `CHK({o_susp_req, o_suspended, o_ready}, 3'h0)
    wait_rdy(1'b0);
    `CHK({o_suspended, o_erase_err}, {1'b0, i_op_fail})
    rd(4'h5, 1'b1);
    done("erase suspend");
    clr;
    issue(2'h1, 4'h2);
    cyc(3);
    i_urgent_irq = 1'b1;
    cyc(1);
    `CHK({o_flash_reset, o_ready}, 2'b10)
    n = 0;
    while (o_flash_reset === 1'b1 && n < 3000) begin cyc(1); n++; end
    `CHK(n, `FRIC_RESTART_CYC)
    cyc(1);
    `CHK({o_urgent_ack, o_ready}, 2'b11)
    i_urgent_irq = 1'b0;
    done("urgent abort");
    op(2'h2, 4'h2, EC, 1'b0);
    ctl(1, 1'b0, 1'b0);
    op(2'h1, 4'h3, PC, 1'b1);
    i_irq = 1'b0;
    i_ce = 1'b0;
    issue(2'h1, 4'h4);
    i_ce = 1'b1;
    cyc(1);
    `CHK(o_ready, 1'b1)
    done("rewrite after abort and ram mode");
    wrap_up;
  end
endmodule
